/* verilog/tpgio_top.sv */
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tpgio_top
    import tpgio_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              general_pin_a_in,
    output logic                   general_pin_a_out,
    output logic                   general_pin_a_oe,
    input  wire logic              general_pin_b_in,
    output logic                   general_pin_b_out,
    output logic                   general_pin_b_oe
);
    logic              pin_a_direction;
    logic              pin_b_direction;
    logic              pin_a_level;
    logic              pin_b_level;
    logic              sel;
    logic              wr_hit;
    logic              rd_hit;
    logic [DATA_W-1:0] reg_view;
    logic [DATA_W-1:0] next_rdata;
    logic              pin_a_seen;
    logic              pin_b_seen;
    logic              read_a;
    logic              read_b;

    tpgio_sync_if #(.WIDTH(PIN_N)) sync_bus ();

    assign sync_bus.raw = {general_pin_b_in, general_pin_a_in};
    assign pin_a_seen   = sync_bus.level[0];
    assign pin_b_seen   = sync_bus.level[1];

    tpgio_sync #(
        .WIDTH (PIN_N)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .pins    (sync_bus)
    );

    assign sel    = (reg_addr == PIN_CTRL_ADDR);
    assign wr_hit = ce && reg_wr && sel;
    assign rd_hit = ce && reg_rd && sel;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_a_direction <= DIR_RESET;
            pin_b_direction <= DIR_RESET;
        end else if (wr_hit) begin
            pin_a_direction <= reg_wdata[DIR_A_BIT];
            pin_b_direction <= reg_wdata[DIR_B_BIT];
        end
    end

    // writes while input are dropped, so the reading is never disturbed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_a_level <= LEVEL_RESET;
        end else if (wr_hit && (reg_wdata[DIR_A_BIT] == DIR_OUTPUT)) begin
            pin_a_level <= reg_wdata[LEVEL_A_BIT];
        end
    end

    // pin b level latch, default high
    // level writes with input direction are ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_b_level <= LEVEL_RESET;
        end else if (wr_hit && (reg_wdata[DIR_B_BIT] == DIR_OUTPUT)) begin
            pin_b_level <= reg_wdata[LEVEL_B_BIT];
        end
    end

    // output enable only while direction is output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_pin_a_oe <= 1'h0;
            general_pin_b_oe <= 1'h0;
        end else if (ce) begin
            general_pin_a_oe <= (next_dir_a() == DIR_OUTPUT);
            general_pin_b_oe <= (next_dir_b() == DIR_OUTPUT);
        end
    end

    // pin drive follows the level latch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_pin_a_out <= LEVEL_RESET;
            general_pin_b_out <= LEVEL_RESET;
        end else if (ce) begin
            general_pin_a_out <= next_lvl_a();
            general_pin_b_out <= next_lvl_b();
        end
    end

    function automatic logic next_dir_a();
        return wr_hit ? reg_wdata[DIR_A_BIT] : pin_a_direction;
    endfunction

    function automatic logic next_dir_b();
        return wr_hit ? reg_wdata[DIR_B_BIT] : pin_b_direction;
    endfunction

    function automatic logic next_lvl_a();
        return (wr_hit && (reg_wdata[DIR_A_BIT] == DIR_OUTPUT)) ?
            reg_wdata[LEVEL_A_BIT] : pin_a_level;
    endfunction

    function automatic logic next_lvl_b();
        return (wr_hit && (reg_wdata[DIR_B_BIT] == DIR_OUTPUT)) ?
            reg_wdata[LEVEL_B_BIT] : pin_b_level;
    endfunction

    // input pins read back their sampled level
    assign read_a = (pin_a_direction == DIR_INPUT) ? pin_a_seen : pin_a_level;
    assign read_b = (pin_b_direction == DIR_INPUT) ? pin_b_seen : pin_b_level;

    always_comb begin
        reg_view                          = IDLE_READ;
        reg_view[RSVD_HI_BIT:RSVD_LO_BIT] = RSVD_VALUE;
        reg_view[LEVEL_B_BIT]             = read_b;
        reg_view[LEVEL_A_BIT]             = read_a;
        reg_view[DIR_B_BIT]               = pin_b_direction;
        reg_view[DIR_A_BIT]               = pin_a_direction;
    end

    // unmapped or idle reads return zero
    assign next_rdata = rd_hit ? reg_view : IDLE_READ;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= IDLE_READ;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end

    sequence s_write_b_out;
        wr_hit && (reg_wdata[DIR_B_BIT] == DIR_OUTPUT);
    endsequence

    sequence s_write_a_out;
        wr_hit && (reg_wdata[DIR_A_BIT] == DIR_OUTPUT);
    endsequence

    sequence s_read_b_input;
        rd_hit && (pin_b_direction == DIR_INPUT);
    endsequence

    sequence s_read_a_input;
        rd_hit && (pin_a_direction == DIR_INPUT);
    endsequence

    // pin b driven per written level
    property p_pin_b_drive;
        @(posedge ref_clk) disable iff (rst)
        s_write_b_out |=> general_pin_b_oe
            && (general_pin_b_out == $past(reg_wdata[LEVEL_B_BIT]));
    endproperty
    a_pin_b_drive: assert property (p_pin_b_drive)
        else $error("pin b not driven with written level");

    property p_pin_b_readback;
        @(posedge ref_clk) disable iff (rst)
        (rd_hit && (pin_b_direction == DIR_OUTPUT))
            |=> (reg_rdata[LEVEL_B_BIT] == general_pin_b_out);
    endproperty
    a_pin_b_readback: assert property (p_pin_b_readback)
        else $error("pin b output level not read back");

    property p_pin_b_input_read;
        @(posedge ref_clk) disable iff (rst)
        s_read_b_input |=> (reg_rdata[LEVEL_B_BIT] == $past(pin_b_seen))
            && !general_pin_b_oe;
    endproperty
    a_pin_b_input_read: assert property (p_pin_b_input_read)
        else $error("pin b input reading wrong");

    // pin a driven per written level
    property p_pin_a_drive;
        @(posedge ref_clk) disable iff (rst)
        s_write_a_out |=> general_pin_a_oe
            && (general_pin_a_out == $past(reg_wdata[LEVEL_A_BIT]));
    endproperty
    a_pin_a_drive: assert property (p_pin_a_drive)
        else $error("pin a not driven with written level");

    // pin a level holds until the next write
    property p_pin_a_hold;
        @(posedge ref_clk) disable iff (rst)
        (general_pin_a_oe && !wr_hit) |=> $stable(general_pin_a_out);
    endproperty
    a_pin_a_hold: assert property (p_pin_a_hold)
        else $error("pin a output changed without a write");

    property p_pin_a_input_read;
        @(posedge ref_clk) disable iff (rst)
        s_read_a_input |=> (reg_rdata[LEVEL_A_BIT] == $past(pin_a_seen))
            && !general_pin_a_oe;
    endproperty
    a_pin_a_input_read: assert property (p_pin_a_input_read)
        else $error("pin a input reading wrong");

    property p_dir_enable;
        @(posedge ref_clk) disable iff (rst)
        ce |=> (general_pin_a_oe == (pin_a_direction == DIR_OUTPUT))
            && (general_pin_b_oe == (pin_b_direction == DIR_OUTPUT));
    endproperty
    a_dir_enable: assert property (p_dir_enable)
        else $error("output enable does not match direction");

    // reset leaves both pins as inputs
    property p_reset_input;
        @(posedge ref_clk)
        rst |=> !general_pin_a_oe && !general_pin_b_oe
            && pin_a_direction && pin_b_direction;
    endproperty
    a_reset_input: assert property (p_reset_input)
        else $error("pins not inputs after reset");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> (reg_rdata[RSVD_HI_BIT:RSVD_LO_BIT] == RSVD_VALUE);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    // input level write leaves pin untouched
    property p_input_write_no_pin;
        @(posedge ref_clk) disable iff (rst)
        (wr_hit && reg_wdata[DIR_B_BIT] && reg_wdata[DIR_A_BIT])
            |=> !general_pin_a_oe && !general_pin_b_oe
            && $stable(general_pin_a_out) && $stable(general_pin_b_out);
    endproperty
    a_input_write_no_pin: assert property (p_input_write_no_pin)
        else $error("input level write altered a pin");

    property p_pin_b_reset_level;
        @(posedge ref_clk)
        rst |=> general_pin_b_out && pin_b_level && general_pin_a_out && pin_a_level;
    endproperty
    a_pin_b_reset_level: assert property (p_pin_b_reset_level)
        else $error("level bits not high after reset");

    // pin b level holds until the next write
    property p_pin_b_hold;
        @(posedge ref_clk) disable iff (rst)
        (general_pin_b_oe && !wr_hit) |=> $stable(general_pin_b_out);
    endproperty
    a_pin_b_hold: assert property (p_pin_b_hold)
        else $error("pin b output changed without a write");

    property p_pin_a_readback;
        @(posedge ref_clk) disable iff (rst)
        (rd_hit && (pin_a_direction == DIR_OUTPUT))
            |=> (reg_rdata[LEVEL_A_BIT] == general_pin_a_out);
    endproperty
    a_pin_a_readback: assert property (p_pin_a_readback)
        else $error("pin a output level not read back");

    // pin b level read-only while input
    property p_pin_b_level_kept;
        @(posedge ref_clk) disable iff (rst)
        (wr_hit && (reg_wdata[DIR_B_BIT] == DIR_INPUT)) |=> $stable(pin_b_level);
    endproperty
    a_pin_b_level_kept: assert property (p_pin_b_level_kept)
        else $error("pin b level changed by a write while input");

    // pin a level ignores input writes
    property p_pin_a_level_kept;
        @(posedge ref_clk) disable iff (rst)
        (wr_hit && (reg_wdata[DIR_A_BIT] == DIR_INPUT)) |=> $stable(pin_a_level);
    endproperty
    a_pin_a_level_kept: assert property (p_pin_a_level_kept)
        else $error("pin a level changed by a write while input");

    // a low clock enable must freeze every output
    property p_ce_freeze;
        @(posedge ref_clk) disable iff (rst)
        !ce |=> $stable(reg_rdata)
            && $stable(general_pin_a_oe) && $stable(general_pin_b_oe)
            && $stable(general_pin_a_out) && $stable(general_pin_b_out);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("outputs moved while clock enable low");

    // with clock enable high, read data stands only in the cycle after the strobe
    property p_read_once;
        @(posedge ref_clk) disable iff (rst)
        (ce && !rd_hit) |=> (reg_rdata == IDLE_READ);
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("read data outside its cycle");
endmodule

/* common/tpgio_pkg.sv */
package tpgio_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PIN_N  = 2;

    localparam logic [ADDR_W-1:0] PIN_CTRL_ADDR = 8'h00;

    localparam int DIR_A_BIT   = 0;
    localparam int DIR_B_BIT   = 1;
    localparam int LEVEL_A_BIT = 2;
    localparam int LEVEL_B_BIT = 3;
    localparam int RSVD_LO_BIT = 4;
    localparam int RSVD_HI_BIT = 7;

    localparam logic       DIR_OUTPUT    = 1'h0;
    localparam logic       DIR_INPUT     = 1'h1;
    localparam logic       DIR_RESET     = 1'h1;
    localparam logic       LEVEL_RESET   = 1'h1;
    localparam logic       PIN_IN_RESET  = 1'h1;
    localparam logic [3:0] RSVD_VALUE    = 4'h0;
    localparam logic [DATA_W-1:0] IDLE_READ = 8'h00;
endpackage

/* common/tpgio_sync_if.sv */
`timescale 1ns/1ps
interface tpgio_sync_if #(parameter int WIDTH = 2);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] level;

    modport sync (input raw, output level);
    modport core (output raw, input level);
endinterface

/* verilog/tpgio_sync.sv */
`timescale 1ns/1ps
module tpgio_sync
    import tpgio_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  ce,
    tpgio_sync_if.sync pins
);
    // three stages per pin; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            logic stage1;
            logic stage2;
            logic stage3;
            logic settled;

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    stage1 <= PIN_IN_RESET;
                    stage2 <= PIN_IN_RESET;
                    stage3 <= PIN_IN_RESET;
                end else if (ce) begin
                    stage1 <= pins.raw[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                end
            end

            // a change only counts once two stages agree, so glitches are dropped
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    settled <= PIN_IN_RESET;
                end else if (ce && (stage2 == stage3)) begin
                    settled <= stage3;
                end
            end

            assign pins.level[i] = settled;
        end
    endgenerate
endmodule

/* verification/tpgio_board.sv */
`timescale 1ns/1ps
module tpgio_board (
    input  wire logic       ref_clk,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    input  wire logic [1:0] drv_en,
    input  wire logic [1:0] drv_val,
    output logic      [1:0] wire_lvl
);
    // a floating wire toggles so a stale level can never pass for a real one
    logic [1:0] float_pat = 2'h1;
    always @(posedge ref_clk) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wire_lvl[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : float_pat[i]);
        end
    end
endmodule

/* verification/two_pin_general_io_control_test.sv */
`timescale 1ns/1ps
module two_pin_general_io_control_test;
    import tpgio_pkg::*;
    logic       ref_clk = 1'h0;
    logic       rst = 1'h1;
    logic       ce = 1'h1;
    logic       reg_wr = 1'h0;
    logic       reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] d;
    logic [1:0] p_out;
    logic [1:0] p_oe;
    logic [1:0] p_in;
    logic [1:0] drv_en = 2'h3;
    logic [1:0] drv_val = 2'h3;
    int         error_cnt = 0;
    int         checks = 0;
    int         seed = 33;
    int         m_dir[2] = '{1, 1};
    int         m_lvl[2] = '{1, 1};

    always #5 ref_clk = ~ref_clk;

    tpgio_top u_tpgio_top (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .general_pin_a_in(p_in[0]), .general_pin_a_out(p_out[0]),
        .general_pin_a_oe(p_oe[0]), .general_pin_b_in(p_in[1]),
        .general_pin_b_out(p_out[1]), .general_pin_b_oe(p_oe[1]));
    tpgio_board u_tpgio_board (.ref_clk(ref_clk), .pin_out(p_out), .pin_oe(p_oe),
        .drv_en(drv_en), .drv_val(drv_val), .wire_lvl(p_in));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_val(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_rd();
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 2; i++) begin
            v[i] = m_dir[i][0];
            v[2+i] = m_dir[i] ? drv_val[i] : m_lvl[i][0];
        end
        return v;
    endfunction

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        if (a == PIN_CTRL_ADDR && ce) begin
            for (int i = 0; i < 2; i++) begin
                m_dir[i] = w[i];
                if (!w[i]) m_lvl[i] = w[2+i];
            end
        end
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] r);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        r = reg_rdata;
    endtask

    task automatic check_rd();
        logic [7:0] r;
        bus_rd(PIN_CTRL_ADDR, r);
        check_val("pin control read", r, exp_rd());
    endtask

    task automatic check_pins();
        for (int i = 0; i < 2; i++) begin
            check_val("pin oe", 8'(p_oe[i]), 8'(m_dir[i] == 0));
            if (m_dir[i] == 0) begin
                check_val("pin out", 8'(p_out[i]), 8'(m_lvl[i]));
                check_val("pin wire", 8'(p_in[i]), 8'(m_lvl[i]));
            end
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        #1;
        check_pins();
        check_val("reset out", 8'(p_out), 8'h03);
        check_rd();
        @(posedge ref_clk);
        #1;
        check_val("idle rdata", reg_rdata, IDLE_READ);
        $display("test reset done");
        drv_en <= 2'h0;
        for (int k = 0; k < 8; k++) begin
            d = (k < 4) ? 8'(k << 2) : (8'($random(seed)) & 8'hFC);
            bus_wr(PIN_CTRL_ADDR, d);
            check_pins();
            check_rd();
        end
        $display("test output done");
        drv_en <= 2'h3;
        bus_wr(PIN_CTRL_ADDR, 8'h03);
        for (int k = 0; k < 4; k++) begin
            drv_val <= 2'(k);
            repeat (6) @(posedge ref_clk);
            #1;
            check_rd();
            bus_wr(PIN_CTRL_ADDR, 8'($random(seed)) | 8'h03);
            check_pins();
            check_rd();
        end
        $display("test input done");
        drv_en <= 2'h2;
        drv_val <= 2'h0;
        bus_wr(PIN_CTRL_ADDR, 8'h06);
        repeat (6) @(posedge ref_clk);
        #1;
        check_pins();
        check_rd();
        bus_wr(8'h01, 8'h00);
        check_pins();
        bus_rd(8'h01, d);
        check_val("unmapped read", d, 8'h00);
        ce <= 1'h0;
        bus_wr(PIN_CTRL_ADDR, 8'h00);
        ce <= 1'h1;
        check_rd();
        $display("test mixed done");
        rst <= 1'h1;
        drv_en <= 2'h3;
        drv_val <= 2'h3;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        m_dir = '{1, 1};
        m_lvl = '{1, 1};
        repeat (6) @(posedge ref_clk);
        #1;
        check_pins();
        check_rd();
        $display("test second reset done");
        complete_run();
    end
endmodule
